// ==== rtl/sys_cfg_pkg.sv ====
// System-area parameter loader constants: addresses, defaults, widths.
// Assumes a byte-wide nonvolatile memory with a single-cycle read port.
package sys_cfg_pkg;
  // ----------------------------------------
  // Address space
  // ----------------------------------------
  localparam int ADDR_W = 9;
  localparam logic [8:0] ADDR_LAST = 9'h1ff;
  localparam logic [8:0] BLOCK_SIZE = 9'h010;
  localparam int BLOCK_SHIFT = 4;
  localparam logic [8:0] BYTE_MASK = 9'h00f;
  // ----------------------------------------
  // Deferred parameter bytes
  // ----------------------------------------
  localparam logic [8:0] ADDR_SYS_CODE = 9'h1e0;
  localparam logic [8:0] ADDR_CARD_ID = 9'h1e2;
  localparam logic [8:0] ADDR_RESP_TIME = 9'h1ea;
  localparam logic [8:0] ADDR_APP_FAMILY = 9'h1ec;
  localparam logic [8:0] ADDR_FRAME_WAIT = 9'h1ed;
  localparam logic [8:0] ADDR_HW_FIRST = 9'h1fb;
  localparam logic [8:0] ADDR_HW_SECOND = 9'h1fc;
  localparam logic [8:0] ADDR_TUNNEL = 9'h1fd;
  // Immediate-effect settings
  localparam logic [8:0] ADDR_RF_WP = 9'h1f0;
  localparam logic [8:0] ADDR_SER_WP = 9'h1f1;
  localparam logic [8:0] ADDR_SECURITY = 9'h1f2;
  // Validity bytes
  localparam logic [8:0] ADDR_VALID_FLAG = 9'h1fe;
  localparam logic [8:0] ADDR_CHECK_CODE = 9'h1ff;
  localparam logic [7:0] VALID_FLAG_ON = 8'h01;
  // ----------------------------------------
  // Defaults
  // ----------------------------------------
  localparam logic [7:0] RST_APP_FAMILY = 8'h00;
  localparam logic [7:0] RST_FRAME_WAIT = 8'he0;
  localparam logic [15:0] RST_SYS_CODE = 16'haaff;
  localparam logic [63:0] RST_CARD_ID = 64'h02fe000000000000;
  localparam logic [15:0] RST_RESP_TIME = 16'hffff;
  localparam logic [7:0] RST_HW_FIRST = 8'h00;
  localparam logic [7:0] RST_HW_SECOND = 8'hf0;
  localparam logic [7:0] RST_TUNNEL = 8'h47;
  localparam logic [7:0] RST_PROTECT = 8'h00;
  // Number of bytes loaded at start-up: the deferred bytes plus the flag byte
  localparam logic [4:0] LOAD_COUNT = 5'h12;
endpackage : sys_cfg_pkg

// ==== rtl/system_area_config_loader.sv ====
// Loads the system-area parameters from nonvolatile memory and applies them.
// Assumes the memory returns read data one cycle after o_nv_rd_en, and that
// power-up and the serial self-reset both arrive as assertion of i_rst_b.
// Summary of operation
// - Family identifier byte at 0x1ec, default 0x00
// - Frame wait byte at 0x1ed, default 0xe0
// - Stored values used only if flag, check valid
// - Write-protect and security settings apply immediately, only while stored values are valid
// - Other parameters apply after power cycle, self-reset
// - Power off needs supply and RF both absent
// - Map physical address to block and byte index
module system_area_config_loader
  import sys_cfg_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Power presence, from pins
  input wire logic i_external_supply,
  input wire logic i_rf_power,
  // Nonvolatile memory read port
  output logic o_nv_rd_en,
  output logic [8:0] o_nv_addr,
  input wire logic [7:0] i_nv_rd_data,
  // Write completion notice from the memory writer
  input wire logic i_nv_wr_done,
  input wire logic [8:0] i_nv_wr_addr,
  input wire logic [7:0] i_nv_wr_data,
  // Address translation
  input wire logic [8:0] i_phys_addr,
  output logic [8:0] o_serial_addr,
  output logic [8:0] o_iso_addr,
  output logic [4:0] o_block_num,
  output logic [3:0] o_byte_index,
  // Applied parameters
  output logic o_load_done,
  output logic o_power_off,
  output logic [7:0] o_application_family_id,
  output logic [7:0] o_frame_wait_integer,
  output logic [15:0] o_card_system_code,
  output logic [63:0] o_card_identifier,
  output logic [15:0] o_response_time_params,
  output logic [7:0] o_hardware_params_first,
  output logic [7:0] o_hardware_params_second,
  output logic [7:0] o_tunnel_timeout_params,
  output logic [7:0] o_rf_write_protect_setting,
  output logic [7:0] o_serial_write_protect_setting,
  output logic [7:0] o_security_setting
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Check code: complement of the XOR over the flag and deferred bytes
  function automatic logic [7:0] check_step(input logic [7:0] acc, input logic [7:0] b);
    check_step = acc ^ b;
  endfunction : check_step

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_CHECK = 4'b0100,
    ST_RUN = 4'b1000
  } load_e;

  load_e state;
  logic [4:0] rd_idx;
  logic [4:0] cap_idx;
  logic cap_valid;
  logic [7:0] raw [0:17];
  logic [7:0] check_acc;
  logic stored_ok;
  logic [1:0] ext_sync;
  logic [1:0] rf_sync;
  logic [8:0] next_rd_addr;

  // Read addresses: 0x1e0..0x1ed, 0x1fb..0x1fe
  always_comb
  begin
    if (rd_idx < 5'h0e)
      next_rd_addr = ADDR_SYS_CODE + {4'h0, rd_idx};
    else
      next_rd_addr = ADDR_HW_FIRST + {4'h0, rd_idx - 5'h0e};
  end

  // Power pins come from outside the clock domain
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      // Reset as present: a restart under power must not report power off
      ext_sync <= 2'b11;
      rf_sync <= 2'b11;
    end
    else
    begin
      ext_sync <= {ext_sync[0], i_external_supply};
      rf_sync <= {rf_sync[0], i_rf_power};
    end
  end

  // Off only when both sources are gone; off ends in a reset upstream
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_power_off <= 1'b0;
    else
      o_power_off <= !ext_sync[1] && !rf_sync[1];
  end

  // ----------------------------------------
  // Start-up load sequence
  // ----------------------------------------
  // One pass after every reset; never reruns, so later rewrites wait
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= ST_IDLE;
      rd_idx <= 5'h00;
      o_nv_rd_en <= 1'b0;
      o_nv_addr <= 9'h000;
      o_load_done <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          state <= ST_READ;
          rd_idx <= 5'h00;
        end
        ST_READ:
        begin
          o_nv_rd_en <= (rd_idx < LOAD_COUNT);
          o_nv_addr <= (rd_idx < LOAD_COUNT) ? next_rd_addr : ADDR_CHECK_CODE;
          rd_idx <= rd_idx + 5'h01;
          if (rd_idx == LOAD_COUNT)
          begin
            o_nv_rd_en <= 1'b1;
            state <= ST_CHECK;
          end
        end
        ST_CHECK:
        begin
          o_nv_rd_en <= 1'b0;
          if (!cap_valid)
          begin
            state <= ST_RUN;
            o_load_done <= 1'b1;
          end
        end
        ST_RUN:
          state <= ST_RUN;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Capture read data one cycle after each request
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cap_valid <= 1'b0;
      cap_idx <= 5'h00;
      check_acc <= 8'h00;
      stored_ok <= 1'b0;
    end
    else
    begin
      cap_valid <= o_nv_rd_en;
      cap_idx <= rd_idx - 5'h01;
      if (cap_valid && cap_idx < LOAD_COUNT)
      begin
        raw[cap_idx] <= i_nv_rd_data;
        check_acc <= check_step(check_acc, i_nv_rd_data);
      end
      else if (cap_valid)
        // Flag byte (last loaded) and check code must both be right
        stored_ok <= (raw[17] == VALID_FLAG_ON) && (i_nv_rd_data == ~check_acc);
    end
  end

  // ----------------------------------------
  // Deferred parameters, applied once per reset
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_application_family_id <= RST_APP_FAMILY;
      o_frame_wait_integer <= RST_FRAME_WAIT;
      o_card_system_code <= RST_SYS_CODE;
      o_card_identifier <= RST_CARD_ID;
      o_response_time_params <= RST_RESP_TIME;
      o_hardware_params_first <= RST_HW_FIRST;
      o_hardware_params_second <= RST_HW_SECOND;
      o_tunnel_timeout_params <= RST_TUNNEL;
    end
    else if (state == ST_CHECK && !cap_valid && stored_ok)
    begin
      // Latched here only; rewrites after this point are ignored
      o_card_system_code <= {raw[0], raw[1]};
      o_card_identifier <= {raw[2], raw[3], raw[4], raw[5], raw[6], raw[7], raw[8], raw[9]};
      o_response_time_params <= {raw[10], raw[11]};
      o_application_family_id <= raw[12];
      o_frame_wait_integer <= raw[13];
      o_hardware_params_first <= raw[14];
      o_hardware_params_second <= raw[15];
      o_tunnel_timeout_params <= raw[16];
    end
  end

  // ----------------------------------------
  // Immediate-effect settings
  // ----------------------------------------
  // Follow each completed write at once while the configuration is valid
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rf_write_protect_setting <= RST_PROTECT;
      o_serial_write_protect_setting <= RST_PROTECT;
      o_security_setting <= RST_PROTECT;
    end
    else if (i_nv_wr_done && stored_ok && o_load_done)
    begin
      if (i_nv_wr_addr == ADDR_RF_WP)
        o_rf_write_protect_setting <= i_nv_wr_data;
      if (i_nv_wr_addr == ADDR_SER_WP)
        o_serial_write_protect_setting <= i_nv_wr_data;
      if (i_nv_wr_addr == ADDR_SECURITY)
        o_security_setting <= i_nv_wr_data;
    end
  end

  // ----------------------------------------
  // Address translation
  // ----------------------------------------
  // Registered so the outputs are clean; one cycle of latency
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_serial_addr <= 9'h000;
      o_iso_addr <= 9'h000;
      o_block_num <= 5'h00;
      o_byte_index <= 4'h0;
    end
    else
    begin
      o_serial_addr <= i_phys_addr;
      o_iso_addr <= i_phys_addr;
      o_block_num <= i_phys_addr[8:BLOCK_SHIFT];
      o_byte_index <= i_phys_addr[3:0];
    end
  end

endmodule : system_area_config_loader

// ==== tb/nv_mem_model.sv ====
// Memory stand-in for the loader's one-cycle read port.
// Assumes the bench fills mem by hierarchy.
module nv_mem_model (
  input wire logic i_clk,
  input wire logic i_rd_en,
  input wire logic [8:0] i_addr,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [512];
  // Byte lasts one cycle, then flips so stale reads show
  always @(posedge i_clk)
    o_data <= i_rd_en ? mem[i_addr] : ~o_data;
endmodule : nv_mem_model

// ==== tb/system_area_config_loader_assertions.sv ====
// Port checker for the system-area loader.
// Assumes one clock domain; bound below.
module sys_cfg_checker
  import sys_cfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_external_supply,
  input wire logic i_rf_power,
  input wire logic i_nv_wr_done,
  input wire logic [8:0] i_nv_wr_addr,
  input wire logic [7:0] i_nv_wr_data,
  input wire logic [8:0] i_phys_addr,
  input wire logic [8:0] o_serial_addr,
  input wire logic [4:0] o_block_num,
  input wire logic [3:0] o_byte_index,
  input wire logic o_load_done,
  input wire logic o_power_off,
  input wire logic [7:0] o_application_family_id,
  input wire logic [7:0] o_frame_wait_integer,
  input wire logic [7:0] o_rf_write_protect_setting
);
  timeunit 1ns;
  timeprecision 100ps;
  logic no_pwr;
  // Off only when both sources are gone
  assign no_pwr = !i_external_supply && !i_rf_power;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_addr_copy:
    assert property ($past(i_rst_b) |-> o_serial_addr == $past(i_phys_addr)) else $error("copy");
  chk_block_split:
    assert property ($past(i_rst_b) |-> {o_block_num, o_byte_index} == $past(i_phys_addr))
      else $error("split");
  chk_off_set:
    assert property (no_pwr [*4] |=> o_power_off) else $error("off missed");
  chk_off_clear:
    assert property ((!no_pwr) [*4] |=> !o_power_off) else $error("false off");
  chk_off_after_reset:
    assert property ($rose(i_rst_b) && !no_pwr |=> !o_power_off ##1 !o_power_off)
      else $error("off after reset");
  chk_default_pre:
    assert property (!o_load_done |-> o_application_family_id == RST_APP_FAMILY
      && o_frame_wait_integer == RST_FRAME_WAIT) else $error("default");
  chk_deferred_hold:
    assert property ($past(o_load_done) |-> $stable(o_application_family_id)
      && $stable(o_frame_wait_integer)) else $error("moved");
  chk_load_bound:
    assert property ($rose(i_rst_b) |-> ##[1:40] o_load_done) else $error("slow load");
  chk_protect_cause:
    assert property ($past(o_load_done) && $changed(o_rf_write_protect_setting) |->
      $past(i_nv_wr_done) && $past(i_nv_wr_addr) == ADDR_RF_WP
      && o_rf_write_protect_setting == $past(i_nv_wr_data)) else $error("protect");
  // Main scenarios
  cover property ($rose(o_load_done));
  cover property (i_nv_wr_done && o_load_done);
  cover property (no_pwr [*4]);
endmodule : sys_cfg_checker

bind system_area_config_loader sys_cfg_checker i_chk (.*);

// ==== tb/system_area_config_loader_bench.sv ====
// Self-checking bench for the system-area loader and its memory model.
// Assumes the load ends within 40 cycles of reset release.
module system_area_config_loader_bench
  import sys_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_external_supply = 1'b1, i_rf_power = 1'b0;
  logic i_nv_wr_done = 1'b0, o_nv_rd_en, o_load_done, o_power_off;
  logic [8:0] i_nv_wr_addr = 9'h000, i_phys_addr = 9'h000, o_nv_addr, o_serial_addr, o_iso_addr;
  logic [7:0] i_nv_wr_data = 8'h00, i_nv_rd_data, o_application_family_id, o_frame_wait_integer;
  logic [7:0] o_hardware_params_first, o_hardware_params_second, o_tunnel_timeout_params;
  logic [7:0] o_rf_write_protect_setting, o_serial_write_protect_setting, o_security_setting;
  logic [15:0] o_card_system_code, o_response_time_params;
  logic [63:0] o_card_identifier, old;
  logic [4:0] o_block_num;
  logic [3:0] o_byte_index;
  logic [8:0] a;
  logic [23:0] pv;
  logic [31:0] seed = 32'h000095b9;
  int err_total = 0, cmp_count = 0;
  int img [512];
  wire logic [63:0] par = {o_application_family_id, o_frame_wait_integer, o_card_system_code,
    o_response_time_params, o_hardware_params_first, o_hardware_params_second};
  // Clock, 50 ns period
  always #25 i_clk = ~i_clk;
  system_area_config_loader i_dut (.*);
  nv_mem_model i_mem (.i_clk(i_clk), .i_rd_en(o_nv_rd_en), .i_addr(o_nv_addr),
    .o_data(i_nv_rd_data));
  // Helpers: random source, byte image, expectations
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] b(input int x);
    return img[x][7:0];
  endfunction : b
  function automatic logic [7:0] code();
    logic [7:0] x = 8'h00;
    for (int i = 'h1e0; i < 'h1ff; i++)
      if (i < 'h1ee || i > 'h1fa)
        x ^= b(i);
    return ~x;
  endfunction : code
  function automatic logic [63:0] exp_p(input bit ok);
    if (!ok)
      return {RST_APP_FAMILY, RST_FRAME_WAIT, RST_SYS_CODE, RST_RESP_TIME, RST_HW_FIRST,
        RST_HW_SECOND};
    return {b('h1ec), b('h1ed), b('h1e0), b('h1e1), b('h1ea), b('h1eb), b('h1fb), b('h1fc)};
  endfunction : exp_p
  function automatic logic [63:0] exp_id(input bit ok);
    if (!ok)
      return RST_CARD_ID;
    return {b('h1e2), b('h1e3), b('h1e4), b('h1e5), b('h1e6), b('h1e7), b('h1e8), b('h1e9)};
  endfunction : exp_id
  task automatic put(input int x, input logic [7:0] d);
    img[x] = d;
    i_mem.mem[x] = d;
  endtask : put
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  // Inputs move 2 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask : tick
  task automatic wr(input logic [8:0] x, input logic [7:0] d);
    tick(1);
    i_nv_wr_done = 1'b1;
    i_nv_wr_addr = x;
    i_nv_wr_data = d;
    put(x, d);
  endtask : wr
  // Mode 1 spoils the flag, mode 2 the check code
  task automatic fill(input int m);
    for (int i = 'h1e0; i < 'h1fe; i++)
      put(i, 8'(rnd()));
    put('h1fe, m == 1 ? 8'h02 : VALID_FLAG_ON);
    put('h1ff, code() ^ 8'(m == 2));
  endtask : fill
  task automatic reset_dut();
    tick(1);
    i_rst_b = 1'b0;
    tick(10);
    i_rst_b = 1'b1;
    for (int n = 0; n < 40 && o_load_done !== 1'b1; n++)
      tick(1);
    check(o_load_done, 64'h1);
  endtask : reset_dut
  // Main sequence
  initial
  begin
    for (int m = 2; m >= 0; m--)
    begin
      fill(m);
      reset_dut();
      check(par, exp_p(m == 0));
      check(o_card_identifier, exp_id(m == 0));
      check(64'(o_tunnel_timeout_params), m == 0 ? 64'(b('h1fd)) : 64'(RST_TUNNEL));
      pv = 24'(rnd());
      wr(ADDR_RF_WP, pv[23:16]);
      wr(ADDR_SER_WP, pv[15:8]);
      wr(ADDR_SECURITY, pv[7:0]);
      tick(1);
      i_nv_wr_done = 1'b0;
      tick(1);
      check({o_rf_write_protect_setting, o_serial_write_protect_setting,
        o_security_setting}, m == 0 ? 64'(pv) : 64'h0);
    end
    old = exp_p(1'b1);
    wr(ADDR_APP_FAMILY, 8'(rnd()));
    wr(ADDR_FRAME_WAIT, 8'(rnd()));
    wr(ADDR_CHECK_CODE, code());
    tick(1);
    i_nv_wr_done = 1'b0;
    tick(2);
    check(par, old);
    reset_dut();
    check(par, exp_p(1'b1));
    check(o_card_identifier, exp_id(1'b1));
    check(64'(o_tunnel_timeout_params), 64'(b('h1fd)));
    for (int k = 0; k < 12; k++)
    begin
      a = k == 0 ? ADDR_LAST : k == 1 ? BLOCK_SIZE : 9'(rnd());
      tick(1);
      i_phys_addr = a;
      tick(1);
      check({o_serial_addr, o_iso_addr, o_block_num, o_byte_index},
        {a, a, 5'(a / 16), 4'(a % 16)});
    end
    for (int p = 0; p < 4; p++)
    begin
      {i_external_supply, i_rf_power} = 2'(p);
      tick(5);
      check(o_power_off, 64'(p == 0));
    end
    end_sim();
  end
  // Watchdog, far beyond the expected run
  initial
  begin
    #(20000 * 50);
    err_total++;
    end_sim();
  end
endmodule : system_area_config_loader_bench
